// ### dpram_dev_model.sv
// behavioural two-port memory seen from the left port
module dpram_dev_model (
  input wire logic ref_clk_i,
  input wire logic ce_n_i,
  input wire logic sem_n_i,
  input wire logic rw_n_i,
  input wire logic oe_n_i,
  input wire logic [12:0] addr_i,
  input wire logic [8:0] data_i,
  output logic [8:0] data_o,
  output logic busy_n_o,
  output logic flag_n_o,
  input wire logic r_we_i,
  input wire logic r_sem_i,
  input wire logic [12:0] r_addr_i,
  input wire logic [8:0] r_d_i,
  input wire logic r_busy_i,
  output logic r_flag_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] mem [8192];
  logic [1:0] tok [8];
  logic [7:0] pl = '0, pr = '0;
  logic ce_q = 1, sem_q = 1, rw_q = 1, rd_q = 0;
  wire rd = !oe_n_i && rw_n_i && !(ce_n_i && sem_n_i);
  assign busy_n_o = !r_busy_i;
  initial begin
    data_o = '0;
    flag_n_o = 1'b1;
    r_flag_n_o = 1'b1;
    // tokens start left-owned so the host must clear them
    for (int i = 0; i < 8; i++) tok[i] = 2'h1;
  end
  task automatic sem_wr(input logic rt, input logic [2:0] s, input logic b);
    if (!b) begin
      if (tok[s] == 2'h0) tok[s] = rt ? 2'h2 : 2'h1;
      else if (rt) pr[s] = tok[s] != 2'h2;
      else pl[s] = tok[s] != 2'h1;
    end else begin
      if (rt) pr[s] = 1'b0; else pl[s] = 1'b0;
      if (tok[s] == (rt ? 2'h2 : 2'h1)) begin
        tok[s] = (rt ? pl[s] : pr[s]) ? (rt ? 2'h1 : 2'h2) : 2'h0;
        pl[s] = 1'b0;
        pr[s] = 1'b0;
      end
    end
  endtask
  always @(negedge ref_clk_i) begin
    if (r_we_i && r_sem_i) sem_wr(1'b1, r_addr_i[2:0], r_d_i[0]);
    if (r_we_i && !r_sem_i) mem[r_addr_i] = r_d_i;
    if (r_we_i && !r_sem_i && r_addr_i == 13'h1ffe) flag_n_o = 1'b0;
    if (ce_n_i && !ce_q && !rw_q) mem[addr_i] = data_i;
    if (ce_n_i && !ce_q && !rw_q && addr_i == 13'h1fff)
      r_flag_n_o = 1'b0;
    if (ce_n_i && !ce_q && rw_q && addr_i == 13'h1ffe) flag_n_o = 1'b1;
    if (sem_n_i && !sem_q && !rw_q) sem_wr(1'b0, addr_i[2:0], data_i[0]);
    if (rd && !rd_q) data_o = !sem_n_i ? {9{tok[addr_i[2:0]] != 2'h1}} :
      mem[addr_i];
    else if (!rd) data_o = ~data_o;
    rd_q = rd;
    ce_q = ce_n_i;
    sem_q = sem_n_i;
    rw_q = rw_n_i;
  end
endmodule

// ### dpram_host_chk.sv
// pin discipline assertions for the host port controller
module dpram_host_chk (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic chip_en_n_o,
  input wire logic sem_sel_n_o,
  input wire logic rw_n_o,
  input wire logic out_en_n_o,
  input wire logic data_oe_n_o,
  input wire logic [dpram_host_pkg::ADDR_W-1:0] addr_o,
  input wire logic req_ready_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence sem_wr_done;
    $rose(sem_sel_n_o) ##0 !$past(rw_n_o);
  endsequence
  a_one_select:
    assert property (!chip_en_n_o |-> sem_sel_n_o)
    else $error("chip enable and semaphore select both low");
  a_read_qualified:
    assert property (!out_en_n_o |-> rw_n_o && !(chip_en_n_o && sem_sel_n_o))
    else $error("output enable low outside a read");
  a_sem_no_enable:
    assert property ($fell(sem_sel_n_o) |-> chip_en_n_o [*2])
    else $error("chip enable low during semaphore access");
  a_write_drives:
    assert property (!rw_n_o && !(chip_en_n_o && sem_sel_n_o) |->
      !data_oe_n_o && out_en_n_o)
    else $error("write strobe without driven data");
  a_addr_steady:
    assert property (!chip_en_n_o && !$past(chip_en_n_o) |-> $stable(addr_o))
    else $error("address moved during strobe");
  a_strobe_width:
    assert property ($fell(chip_en_n_o) |=> !chip_en_n_o)
    else $error("strobe shorter than two cycles");
  a_sem_recovery:
    assert property (sem_wr_done |=> sem_sel_n_o)
    else $error("semaphore reselected without recovery");
  a_idle_quiet:
    assert property (req_ready_o |-> chip_en_n_o && sem_sel_n_o && data_oe_n_o)
    else $error("pins active while idle");
endmodule
bind dpram_port_host dpram_host_chk chk (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .chip_en_n_o(chip_en_n_o), .sem_sel_n_o(sem_sel_n_o),
  .rw_n_o(rw_n_o), .out_en_n_o(out_en_n_o), .data_oe_n_o(data_oe_n_o),
  .addr_o(addr_o), .req_ready_o(req_ready_o));

// ### dpram_host_pkg.sv
// constants and types for the host-side controller of one memory port
package dpram_host_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 9;
  localparam int SEM_N = 8;
  localparam logic [12:0] MBOX_LEFT_ADDR = 13'h1ffe;
  localparam logic [12:0] MBOX_RIGHT_ADDR = 13'h1fff;
  localparam int CLK_NS = 40;
  // access strobe width, address/data setup and flowthrough wait
  localparam int STROBE_NS = 60;
  localparam int SETUP_NS = 20;
  localparam int FLOWTHROUGH_NS = 40;
  localparam int SEM_RECOVERY_NS = 20;
  localparam int BUSY_SETTLE_NS = 40;
  localparam logic [3:0] STROBE_CYC =
    4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] FLOW_CYC =
    4'((FLOWTHROUGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] SEM_REC_CYC =
    4'((SEM_RECOVERY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] BUSY_SETTLE_CYC =
    4'((BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS);
  // edges a pin change takes to reach the logic through the synchroniser
  localparam logic [3:0] SYNC_CYC = 4'h4;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_SEM_READ, OP_SEM_WRITE, OP_SEM_ACQUIRE
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic after_remote;
  } req_t;

  typedef struct packed {
    logic chip_en_n;
    logic sem_sel_n;
    logic rw_n;
    logic out_en_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic dout_en_n;
  } pins_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic granted;
    logic busy_seen;
  } resp_t;
endpackage

// ### dpram_port_host.sv
// host controller driving one port of the two-port memory
module dpram_port_host (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire dpram_host_pkg::req_t req_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output dpram_host_pkg::resp_t resp_o,
  input wire logic init_sems_i,
  input wire logic slave_mode_i,
  output logic chip_en_n_o,
  output logic sem_sel_n_o,
  output logic rw_n_o,
  output logic out_en_n_o,
  output logic [dpram_host_pkg::ADDR_W-1:0] addr_o,
  output logic [dpram_host_pkg::DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  input wire logic [dpram_host_pkg::DATA_W-1:0] data_i,
  input wire logic busy_n_i,
  input wire logic mailbox_flag_n_i,
  output logic mailbox_pending_o
);
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RECOVER, S_INIT
  } state_t;

  typedef struct packed {
    state_t state;
    dpram_host_pkg::req_t req;
    dpram_host_pkg::pins_t pins;
    logic [3:0] cnt;
    logic [2:0] init_idx;
    logic ready;
    logic resp_valid;
    dpram_host_pkg::resp_t resp;
    logic busy_hit;
    logic mbox;
    // acquire polling and start-up release in progress
    logic acq;
    logic init_run;
  } host_state_t;

  host_state_t st_q, st_d;
  logic [dpram_host_pkg::DATA_W-1:0] data_s;
  logic busy_n_s;
  logic flag_n_s;
  logic hold_wr;

  pin_sync #(.W(dpram_host_pkg::DATA_W + 2)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i({data_i, busy_n_i, mailbox_flag_n_i}),
    .level_o({data_s, busy_n_s, flag_n_s})
  );

  // a slave must not start a write while the master reports busy
  assign hold_wr = slave_mode_i && !busy_n_s;

  function automatic logic is_sem(input dpram_host_pkg::op_t op);
    return op == dpram_host_pkg::OP_SEM_READ ||
      op == dpram_host_pkg::OP_SEM_WRITE ||
      op == dpram_host_pkg::OP_SEM_ACQUIRE;
  endfunction

  function automatic logic is_wr(input dpram_host_pkg::op_t op);
    return op == dpram_host_pkg::OP_WRITE ||
      op == dpram_host_pkg::OP_SEM_WRITE ||
      op == dpram_host_pkg::OP_SEM_ACQUIRE;
  endfunction

  function automatic dpram_host_pkg::pins_t idle_pins();
    dpram_host_pkg::pins_t p;
    p = '1;
    p.addr = '0;
    p.dout = '0;
    return p;
  endfunction

  // reads outlast the pin synchroniser; slave writes let busy settle
  function automatic logic [3:0] strobe_len(
      input dpram_host_pkg::op_t op,
      input logic slave);
    logic [3:0] n;
    if (!is_wr(op)) begin
      n = dpram_host_pkg::STROBE_CYC + dpram_host_pkg::SYNC_CYC;
    end else if (slave) begin
      n = dpram_host_pkg::STROBE_CYC + dpram_host_pkg::BUSY_SETTLE_CYC;
    end else begin
      n = dpram_host_pkg::STROBE_CYC;
    end
    return n;
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.resp_valid = 1'b0;
    st_d.mbox = !flag_n_s;
    case (st_q.state)
      S_IDLE: begin
        st_d.pins = idle_pins();
        st_d.ready = 1'b1;
        if (init_sems_i) begin
          // release every semaphore from this side
          st_d.ready = 1'b0;
          st_d.init_idx = '0;
          st_d.req.op = dpram_host_pkg::OP_SEM_WRITE;
          st_d.req.addr = '0;
          st_d.req.wdata = 9'h001;
          st_d.req.after_remote = 1'b0;
          st_d.init_run = 1'b1;
          st_d.acq = 1'b0;
          st_d.state = S_INIT;
        end else if (req_valid_i && st_q.ready) begin
          st_d.ready = 1'b0;
          st_d.req = req_i;
          st_d.busy_hit = 1'b0;
          st_d.acq = 1'b0;
          // wait out the other port's flowthrough before sampling
          st_d.cnt = req_i.after_remote ? dpram_host_pkg::FLOW_CYC
            : 4'h0;
          st_d.state = S_SETUP;
        end
      end
      S_INIT: begin
        st_d.req.addr = {10'h000, st_q.init_idx};
        st_d.cnt = 4'h0;
        st_d.state = S_SETUP;
      end
      S_SETUP: begin
        st_d.pins.addr = st_q.req.addr;
        st_d.pins.dout = st_q.req.op == dpram_host_pkg::OP_SEM_ACQUIRE
          ? 9'h000 : st_q.req.wdata;
        if (st_q.cnt != 4'h0) begin
          st_d.cnt = st_q.cnt - 4'h1;
        end else begin
          // semaphore select replaces chip enable, never both low
          st_d.pins.chip_en_n = is_sem(st_q.req.op);
          st_d.pins.sem_sel_n = !is_sem(st_q.req.op);
          st_d.pins.rw_n = !is_wr(st_q.req.op) ||
            (hold_wr && !is_sem(st_q.req.op));
          st_d.pins.out_en_n = is_wr(st_q.req.op);
          st_d.pins.dout_en_n = !is_wr(st_q.req.op);
          st_d.cnt = strobe_len(st_q.req.op, slave_mode_i);
          st_d.state = S_STROBE;
        end
      end
      S_STROBE: begin
        if (!busy_n_s) begin
          st_d.busy_hit = 1'b1;
        end
        if (hold_wr && is_wr(st_q.req.op) && !is_sem(st_q.req.op)) begin
          // hold off the slave write until busy releases
          st_d.pins.rw_n = 1'b1;
          st_d.cnt = strobe_len(st_q.req.op, 1'b1);
        end else if (st_q.cnt > 4'h1) begin
          st_d.pins.rw_n = !is_wr(st_q.req.op);
          st_d.cnt = st_q.cnt - 4'h1;
        end else begin
          // rising chip enable or semaphore select edge captures the data
          st_d.pins.rw_n = 1'b1;
          st_d.pins.out_en_n = 1'b1;
          st_d.pins.chip_en_n = 1'b1;
          st_d.pins.sem_sel_n = 1'b1;
          st_d.resp.rdata = data_s;
          st_d.state = S_HOLD;
        end
      end
      S_HOLD: begin
        st_d.pins.dout_en_n = 1'b1;
        st_d.cnt = dpram_host_pkg::SEM_REC_CYC;
        st_d.state = S_RECOVER;
      end
      S_RECOVER: begin
        if (st_q.cnt != 4'h0) begin
          st_d.cnt = st_q.cnt - 4'h1;
        end else if (st_q.req.op == dpram_host_pkg::OP_SEM_ACQUIRE) begin
          // read back; a 1 means the other side owns it, poll again
          st_d.req.op = dpram_host_pkg::OP_SEM_READ;
          st_d.acq = 1'b1;
          st_d.state = S_SETUP;
        end else if (st_q.acq
                     && st_q.resp.rdata[0] == 1'b1) begin
          // owned elsewhere: the pending request hands it over later
          st_d.state = S_SETUP;
        end else if (st_q.init_run && st_q.init_idx != 3'h7) begin
          // step to the next latch of the start-up release
          st_d.init_idx = st_q.init_idx + 3'h1;
          st_d.state = S_INIT;
        end else begin
          st_d.init_run = 1'b0;
          st_d.resp.granted = st_q.resp.rdata[0] == 1'b0;
          st_d.resp.busy_seen = st_q.busy_hit;
          st_d.resp_valid = 1'b1;
          st_d.state = S_IDLE;
        end
      end
      default: st_d.state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '{state: S_IDLE, pins: '{chip_en_n: 1'b1, sem_sel_n: 1'b1,
        rw_n: 1'b1, out_en_n: 1'b1, addr: '0, dout: '0,
        dout_en_n: 1'b1}, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign req_ready_o = st_q.ready;
  assign resp_valid_o = st_q.resp_valid;
  assign resp_o = st_q.resp;
  assign chip_en_n_o = st_q.pins.chip_en_n;
  assign sem_sel_n_o = st_q.pins.sem_sel_n;
  assign rw_n_o = st_q.pins.rw_n;
  assign out_en_n_o = st_q.pins.out_en_n;
  assign addr_o = st_q.pins.addr;
  assign data_o = st_q.pins.dout;
  assign data_oe_n_o = st_q.pins.dout_en_n;
  assign mailbox_pending_o = st_q.mbox;
endmodule

// ### dual_port_ram_arbitration_semaphores_tb_top.sv
// self-checking bench for the one-port host controller
module dual_port_ram_arbitration_semaphores_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] op;
    logic [12:0] a;
    logic [8:0] d;
    logic [8:0] e;
  } row_t;
  row_t rows [8] = '{'{3'h1, 13'h0123, 9'h1a5, 9'h0},
    '{3'h0, 13'h0123, 9'h0, 9'h1a5}, '{3'h1, 13'h1fff, 9'h055, 9'h0},
    '{3'h0, 13'h1fff, 9'h0, 9'h055}, '{3'h2, 13'h0007, 9'h0, 9'h1ff},
    '{3'h3, 13'h1ffb, 9'h1fe, 9'h0}, '{3'h2, 13'h0003, 9'h0, 9'h000},
    '{3'h3, 13'h0003, 9'h001, 9'h0}};
  logic ref_clk_i = 0, rst_n_i = 0, req_valid_i = 0, init_sems_i = 0;
  logic r_we = 0, r_sem = 0, ce_n, sem_n, rw_n, oe_n, doe_n;
  logic req_ready_o, resp_valid_o, busy_n, flag_n, pend;
  logic r_busy = 0, slave = 0, rflag_n;
  logic [12:0] addr, r_a = '0;
  logic [8:0] hd, md, pin, r_d = '0;
  dpram_host_pkg::req_t req_i = '0;
  dpram_host_pkg::resp_t resp_o;
  int err_count = 0, checked = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  assign pin = !doe_n ? hd : md;
  dpram_port_host uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .resp_valid_o(resp_valid_o), .resp_o(resp_o), .init_sems_i(init_sems_i),
    .slave_mode_i(slave), .chip_en_n_o(ce_n), .sem_sel_n_o(sem_n),
    .rw_n_o(rw_n), .out_en_n_o(oe_n), .addr_o(addr), .data_o(hd),
    .data_oe_n_o(doe_n), .data_i(pin), .busy_n_i(busy_n),
    .mailbox_flag_n_i(flag_n), .mailbox_pending_o(pend));
  dpram_dev_model dev (.ref_clk_i(ref_clk_i), .ce_n_i(ce_n), .sem_n_i(sem_n),
    .rw_n_i(rw_n), .oe_n_i(oe_n), .addr_i(addr), .data_i(pin), .data_o(md),
    .busy_n_o(busy_n), .flag_n_o(flag_n), .r_we_i(r_we), .r_sem_i(r_sem),
    .r_addr_i(r_a), .r_d_i(r_d), .r_busy_i(r_busy),
    .r_flag_n_o(rflag_n));
  task automatic cmp(input string n, input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // op 7 runs the semaphore initialisation instead of a request
  task automatic go(input logic [2:0] op, input logic [12:0] a,
    input logic [8:0] d, input logic f = 1'b0);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    if (op == 3'h7) init_sems_i <= 1'b1;
    else req_i <= '{dpram_host_pkg::op_t'(op), a, d, f};
    if (op != 3'h7) req_valid_i <= 1'b1;
    while (req_ready_o !== 1'b0 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    init_sems_i <= 1'b0;
    while (resp_valid_o !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    cmp("answer", {8'h0, resp_valid_o}, 9'h1);
  endtask
  task automatic rop(input logic s, input logic [12:0] a, input logic [8:0] d);
    @(posedge ref_clk_i);
    r_we <= 1'b1;
    r_sem <= s;
    r_a <= a;
    r_d <= d;
    @(posedge ref_clk_i);
    r_we <= 1'b0;
  endtask
  initial begin
    @(negedge ref_clk_i);
    cmp("reset pins", {4'h0, ce_n, sem_n, rw_n, oe_n, doe_n}, 9'h01f);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    go(3'h7, 13'h0, 9'h0);
    foreach (rows[i]) begin
      go(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].op[0] == 1'b0) cmp("rdata", resp_o.rdata, rows[i].e);
    end
    go(3'h2, 13'h0003, 9'h0);
    cmp("released", resp_o.rdata, 9'h1ff);
    cmp("right mail", {8'h0, rflag_n}, 9'h0);
    rop(1'b0, 13'h1ffe, 9'h0aa);
    repeat (8) @(negedge ref_clk_i);
    cmp("mail pending", {8'h0, pend}, 9'h1);
    go(3'h0, 13'h1ffe, 9'h0);
    cmp("mail data", resp_o.rdata, 9'h0aa);
    repeat (8) @(negedge ref_clk_i);
    cmp("mail cleared", {8'h0, pend}, 9'h0);
    rop(1'b1, 13'h0002, 9'h0);
    go(3'h2, 13'h0002, 9'h0);
    cmp("denied", resp_o.rdata, 9'h1ff);
    fork
      go(3'h4, 13'h0002, 9'h0);
      begin
        repeat (30) @(posedge ref_clk_i);
        rop(1'b1, 13'h0002, 9'h001);
      end
    join
    cmp("handed over", resp_o.rdata, 9'h000);
    cmp("granted", {8'h0, resp_o.granted}, 9'h1);
    rop(1'b0, 13'h0100, 9'h05a);
    go(3'h0, 13'h0100, 9'h0, 1'b1);
    cmp("remote data", resp_o.rdata, 9'h05a);
    cmp("no busy", {8'h0, resp_o.busy_seen}, 9'h0);
    @(posedge ref_clk_i);
    slave <= 1'b1;
    r_busy <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    fork
      go(3'h1, 13'h0200, 9'h033);
      begin
        repeat (10) @(negedge ref_clk_i);
        cmp("write held", {7'h0, ce_n, rw_n}, 9'h001);
        @(posedge ref_clk_i);
        r_busy <= 1'b0;
      end
    join
    cmp("busy seen", {8'h0, resp_o.busy_seen}, 9'h1);
    go(3'h0, 13'h0200, 9'h0);
    cmp("slave data", resp_o.rdata, 9'h033);
    @(posedge ref_clk_i);
    slave <= 1'b0;
    rst_n_i <= 1'b0;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    cmp("reset ready", {8'h0, req_ready_o}, 9'h0);
    cmp("mid pins", {4'h0, ce_n, sem_n, rw_n, oe_n, doe_n}, 9'h01f);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(negedge ref_clk_i);
    cmp("ready again", {8'h0, req_ready_o}, 9'h1);
    go(3'h0, 13'h0123, 9'h0);
    cmp("after reset", resp_o.rdata, 9'h1a5);
    end_sim();
  end
  initial begin
    #100000;
    err_count++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim();
  end
endmodule

// ### pin_sync.sv
// three-stage synchroniser; output changes when stages two and three agree
module pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_state_t;
  sync_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;
endmodule
